// ===== dv/adc_ctrl_sva.sv
// Purpose: port checks for the over-range and clock control block
// Assumes: bench freezes clk_en only for an even number of cycles, in indication mode
// Notes:   bound from tb_top
`timescale 1ns/1ps
`include "ovr_clk_consts.svh"
module adc_ctrl_sva
(
    input wire logic                ref_clk,           // Clock
    input wire logic                rst,               // Reset
    input wire logic                clk_en,            // Freeze when low
    input wire logic                core_sample_valid, // Strobe
    input wire logic                sysref_in,         // Raw SYSREF
    input wire logic                readback_data,     // Readback
    input wire logic                readback_oe,       // Readback enable
    input wire logic                cfg_wr,            // Write
    input wire logic [`PHASE_W-1:0] cfg_phase_adj,     // Phase in
    input wire logic                shared_pin_out,    // Pin
    input wire logic                shared_pin_oe,     // Pin enable
    input wire logic                over_range_flag,   // Flag
    input wire logic                sample_tick,       // Tick
    input wire logic                link_restart,      // Restart
    input wire logic                sysref_internal,   // Gated SYSREF
    input wire logic [`PHASE_W-1:0] phase_adj          // Phase out
);
    default clocking cb @(posedge ref_clk);
    endclocking
    // Nothing moves while frozen, so checks pause with the clock enable
    default disable iff (rst || !clk_en);
    ////////////////////////////////////////
    // Pin shows the flag, or readback one cycle late
    pin_share_a: assert property ((shared_pin_oe && shared_pin_out == over_range_flag) ||
        (shared_pin_out == $past(readback_data) && shared_pin_oe == $past(readback_oe)))
        else $error("shared pin shows neither source");
    // Fixed short path: two edges from the strobe
    flag_rise_a: assert property ($rose(over_range_flag) |-> $past(core_sample_valid, 2))
        else $error("flag rose without a sample");
    link_pulse_a: assert property (link_restart |=> !link_restart)
        else $error("restart wider than one cycle");
    link_cause_a: assert property (link_restart |-> $past(cfg_wr))
        else $error("restart without a write");
    // Gated SYSREF must follow a raw SYSREF high one cycle earlier
    sysref_gate_a: assert property (sysref_internal |-> $past(sysref_in))
        else $error("gated SYSREF without input");
    set_load_a: assert property (cfg_wr |-> ##2 phase_adj == $past(cfg_phase_adj, 2))
        else $error("phase field not loaded");
    set_hold_a: assert property ($changed(phase_adj) |-> $past(cfg_wr, 2))
        else $error("phase field moved alone");
    // Device ticks come every other cycle, so ticks stay single
    tick_pulse_a: assert property (sample_tick |=> !sample_tick)
        else $error("sample tick doubled");
    cover property ($rose(over_range_flag));
    cover property (link_restart);
    cover property (sysref_internal);
endmodule

// ===== dv/far_side_model.sv
// Purpose: far side: device clock, SYSREF, readback bits, host recalibration
// Assumes: drives 1 ns after each rising edge
// Notes:   readback held low in reset so the pin starts quiet
`timescale 1ns/1ps
module far_side_model
(
    input  wire logic ref_clk,            // Clock
    input  wire logic rst,                // Reset
    input  wire logic sysref_run,         // SYSREF wanted
    input  wire logic link_restart,       // Link restarted
    output logic      device_clock_input, // Device tick
    output logic      sysref_in,          // SYSREF
    output logic      readback_data,      // Readback bit
    output logic      readback_oe,        // Readback enable
    output int        recal_cnt           // Recalibrations
);
    initial
    begin
        {device_clock_input, sysref_in, readback_data, readback_oe} = 4'h0;
        recal_cnt = 0;
    end
    ////////////////////////////////////////
    // Tick every other cycle; readback random so stale bits show
    always @(posedge ref_clk)
    begin
        #1;
        device_clock_input = !device_clock_input && !rst;
        readback_data = !rst && 1'($urandom);
        readback_oe = !rst && 1'($urandom);
        sysref_in = sysref_run && !sysref_in;
        recal_cnt += int'(link_restart);
    end
endmodule

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the over-range and clock control block
// Assumes: far side ticks the device clock every other cycle
// Notes:   clk_en dropped once, for an even number of cycles, to check the freeze
`timescale 1ns/1ps
`include "ovr_clk_consts.svh"
module tb_top;
    logic                     ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic [`SAMPLE_W-1:0]     core_sample = 16'h0000;
    logic                     core_sample_valid = 1'b0, frame_tick = 1'b0, sysref_run = 1'b0;
    logic                     cfg_wr = 1'b0, cfg_indicate_mode = 1'b0, cfg_sysref_gate_en = 1'b0;
    logic [`THR_W-1:0]        cfg_threshold = 9'h1FF;
    logic [`HOLD_SEL_W-1:0]   cfg_hold_sel = 2'h0;
    ovr_clk_pkg::div_sel_type cfg_div_sel = ovr_clk_pkg::DIV_BY_1, cur_div = ovr_clk_pkg::DIV_BY_1;
    ovr_clk_pkg::div_sel_type seq [4] = '{ovr_clk_pkg::DIV_BY_2, ovr_clk_pkg::DIV_BY_2,
                                          ovr_clk_pkg::DIV_BY_4, ovr_clk_pkg::DIV_BY_1};
    logic [`PHASE_W-1:0]      cfg_phase_adj = 4'h0, phase_adj;
    logic [`AMP_W-1:0]        cfg_amp_adj = 3'h0, amp_adj;
    logic [`DRV_W-1:0]        cfg_swing = 3'h0, cfg_deemph = 3'h0, output_swing_setting, deemphasis_setting;
    logic                     device_clock_input, sysref_in, readback_data, readback_oe;
    logic                     shared_pin_out, shared_pin_oe, over_range_flag, sample_tick;
    logic                     link_restart, sysref_internal;
    int                       err_total = 0, n_checks = 0, restarts = 0, recal_cnt, cnt, lim, n;

    always #2 ref_clk = ~ref_clk;

    adc_overrange_and_clock_ctrl DUT
    (
        .ref_clk, .rst, .clk_en, .core_sample, .core_sample_valid, .frame_tick, .device_clock_input,
        .sysref_in, .readback_data, .readback_oe, .cfg_wr, .cfg_indicate_mode, .cfg_threshold,
        .cfg_hold_sel, .cfg_div_sel, .cfg_sysref_gate_en, .cfg_phase_adj, .cfg_amp_adj, .cfg_swing,
        .cfg_deemph, .shared_pin_out, .shared_pin_oe, .over_range_flag, .sample_tick, .link_restart,
        .sysref_internal, .phase_adj, .amp_adj, .output_swing_setting, .deemphasis_setting
    );
    far_side_model u_far
    (
        .ref_clk, .rst, .sysref_run, .link_restart, .device_clock_input, .sysref_in,
        .readback_data, .readback_oe, .recal_cnt
    );
    ////////////////////////////////////////
    // Compare, count, report
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Inputs move 1 ns after an edge, never on it
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // One write; outputs settle two edges later; model counts factor changes
    task automatic wr();
        if (cfg_div_sel !== cur_div)
            restarts++;
        cur_div = cfg_div_sel;
        cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        tick(2);
    endtask
    task automatic smp(input int mag, input logic neg);
        core_sample = neg ? 16'(-mag) : 16'(mag);
        core_sample_valid = 1'b1;
        tick(1);
        core_sample_valid = 1'b0;
        tick(3);
    endtask
    task automatic frames(input int k);
        repeat (k)
        begin
            frame_tick = 1'b1;
            tick(1);
            frame_tick = 1'b0;
            tick(1);
        end
        tick(2);
    endtask
    task automatic sys_watch(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (20)
        begin
            seen |= (sysref_internal === 1'b1);
            tick(1);
        end
        chk("sysref_internal", seen, exp);
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(32'h067CAF2B));
        tick(2);
        rst = 1'b0;
        tick(1);
        chk("reset outputs", {phase_adj, amp_adj, output_swing_setting, deemphasis_setting}, 0);
        for (int i = 0; i < 8; i++)
        begin
            cfg_swing = 3'(i);
            cfg_deemph = 3'(7 - i);
            cfg_phase_adj = 4'($urandom);
            cfg_amp_adj = 3'($urandom);
            wr();
            chk("drivers", {output_swing_setting, deemphasis_setting}, {cfg_swing, cfg_deemph});
            chk("balance", {phase_adj, amp_adj}, {cfg_phase_adj, cfg_amp_adj});
        end
        // each factor; a repeat must not restart
        foreach (seq[d])
        begin
            cfg_div_sel = seq[d];
            wr();
            tick(8);
            cnt = 0;
            repeat (80)
            begin
                cnt += int'(sample_tick === 1'b1);
                tick(1);
            end
            chk("sample ticks", 16'(cnt), 16'(40 >> int'(cfg_div_sel)));
        end
        chk("restarts", 16'(recal_cnt), 16'(restarts));
        // each hold, both signs, exact boundary
        cfg_indicate_mode = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            cfg_hold_sel = 2'(s);
            cfg_threshold = 9'(1 + $urandom_range(254));
            wr();
            lim = int'(cfg_threshold) * 128;
            n = (s == 0) ? 0 : (2 << s) - 1;
            smp(lim + 1, s[0]);
            chk("flag on", {over_range_flag, shared_pin_out, shared_pin_oe}, 3'h7);
            smp(lim, !s[0]);
            if (n > 0)
            begin
                frames(n - 1);
                chk("flag held", over_range_flag, 1'h1);
                smp(lim + 1, 1'b0);
                smp(lim, 1'b1);
                frames(n - 1);
                chk("flag rehold", over_range_flag, 1'h1);
                frames(1);
            end
            chk("flag off", {over_range_flag, shared_pin_out, shared_pin_oe}, 3'h1);
        end
        // Freeze: a write and an excess while clk_en is low leave no trace;
        // an even freeze length keeps the resumed divider ticks single
        n = int'(cfg_swing);
        {clk_en, cfg_wr, core_sample_valid} = 3'h3;
        cfg_swing = ~cfg_swing;
        core_sample = 16'h7FFF;
        tick(4);
        {clk_en, cfg_wr, core_sample_valid} = 3'h4;
        tick(3);
        chk("frozen", {over_range_flag, output_swing_setting}, 16'(n));
        sysref_run = 1'b1;
        sys_watch(1'b0);
        cfg_sysref_gate_en = 1'b1;
        wr();
        sys_watch(1'b1);
        cfg_sysref_gate_en = 1'b0;
        wr();
        sys_watch(1'b0);
        sysref_run = 1'b0;
        conclude();
    end
    // A hang still ends in the verdict
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        conclude();
    end
endmodule

bind adc_overrange_and_clock_ctrl adc_ctrl_sva u_sva
(
    .ref_clk, .rst, .clk_en, .core_sample_valid, .sysref_in, .readback_data, .readback_oe, .cfg_wr,
    .cfg_phase_adj, .shared_pin_out, .shared_pin_oe, .over_range_flag, .sample_tick,
    .link_restart, .sysref_internal, .phase_adj
);

// ===== src/adc_overrange_and_clock_ctrl.sv
// Purpose: over-range detect, clock divide, SYSREF gate and analog settings
// Assumes: all inputs synchronous to ref_clk; frame ticks are one-cycle pulses
// Notes:   settings arrive as plain ports from the configuration host logic
// How it works
// - Shared pin gives serial readback after reset until indication mode chosen.
// - In indication mode pin is high while input exceeds threshold.
// - Flag path skips pipeline and link; two registers of delay.
// - Threshold steps are 128 codes of the 16-bit range.
// - After input drops, hold counter runs; flag falls when count reached.
// - Hold choices 3, 7, 15 frame clock cycles.
// - Hold resets to zero, flag falls immediately on drop.
// - Device clock divided by one, two or four for sample rate.
// - Changing divide factor restarts serial link initialization.
// - SYSREF passes only when gate enable is set.
// - Closed gate keeps spurious SYSREF edges from alignment logic.
// - Gate enable resets closed; SYSREF ignored until opened.
// - Four-bit phase and three-bit amplitude balance fields held.
// - Balance fields reset to neutral, no correction.
// - Eight swing and eight de-emphasis settings per driver.
`timescale 1ns/1ps
`include "ovr_clk_consts.svh"

module adc_overrange_and_clock_ctrl
(
    input  wire logic                        ref_clk,            // 250 MHz clock
    input  wire logic                        rst,                // Async reset, high
    input  wire logic                        clk_en,             // Freeze when low
    input  wire logic [`SAMPLE_W-1:0]        core_sample,        // Core output, two's complement
    input  wire logic                        core_sample_valid,  // Sample strobe
    input  wire logic                        frame_tick,         // Frame clock tick
    input  wire logic                        device_clock_input, // Device clock tick
    input  wire logic                        sysref_in,          // SYSREF input
    input  wire logic                        readback_data,      // Serial readback bit
    input  wire logic                        readback_oe,        // Readback drive enable
    input  wire logic                        cfg_wr,             // Settings write strobe
    input  wire logic                        cfg_indicate_mode,  // Pin in indication mode
    input  wire logic [`THR_W-1:0]           cfg_threshold,      // Threshold in 128-code steps
    input  wire logic [`HOLD_SEL_W-1:0]      cfg_hold_sel,       // Hold selection
    input  wire ovr_clk_pkg::div_sel_type    cfg_div_sel,        // Clock divide factor
    input  wire logic                        cfg_sysref_gate_en, // SYSREF gate enable
    input  wire logic [`PHASE_W-1:0]         cfg_phase_adj,      // Phase mismatch setting
    input  wire logic [`AMP_W-1:0]           cfg_amp_adj,        // Amplitude mismatch setting
    input  wire logic [`DRV_W-1:0]           cfg_swing,          // Output swing setting
    input  wire logic [`DRV_W-1:0]           cfg_deemph,         // De-emphasis setting
    output logic                             shared_pin_out,     // Shared pin level
    output logic                             shared_pin_oe,      // Shared pin drive enable
    output logic                             over_range_flag,    // Indication, raw
    output logic                             sample_tick,        // Divided sample tick
    output logic                             link_restart,       // Link init restart pulse
    output logic                             sysref_internal,    // Gated SYSREF
    output logic [`PHASE_W-1:0]              phase_adj,          // Phase correction field
    output logic [`AMP_W-1:0]                amp_adj,            // Amplitude correction field
    output logic [`DRV_W-1:0]                output_swing_setting, // Driver swing
    output logic [`DRV_W-1:0]                deemphasis_setting  // Driver de-emphasis
);

    ////////////////////////////////////////////////////////////////////////////
    // Settings registers

    logic                        indicate_reg;
    logic [`THR_W-1:0]           thr_reg;
    logic [`HOLD_SEL_W-1:0]      hold_sel_reg;
    ovr_clk_pkg::div_sel_type    div_reg;
    logic                        gate_reg;
    logic [`PHASE_W-1:0]         phase_reg;
    logic [`AMP_W-1:0]           amp_reg;
    logic [`DRV_W-1:0]           swing_reg;
    logic [`DRV_W-1:0]           deemph_reg;
    logic                        div_change;

    // A write only restarts the link when the factor really changes
    assign div_change = cfg_wr & (cfg_div_sel != div_reg);

    // Pin mode and detector settings; reset leaves the pin in readback
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            indicate_reg <= 1'b0;
            thr_reg      <= `THR_RESET;
            hold_sel_reg <= `HOLD_SEL_RESET;
        end
        else if (clk_en && cfg_wr)
        begin
            indicate_reg <= cfg_indicate_mode;
            thr_reg      <= cfg_threshold;
            hold_sel_reg <= cfg_hold_sel;
        end
    end

    // Divider and SYSREF gate settings; only a divider change disturbs the link
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            div_reg      <= ovr_clk_pkg::div_sel_type'(`DIV_SEL_RESET);
            gate_reg     <= 1'b0;
        end
        else if (clk_en && cfg_wr)
        begin
            div_reg      <= cfg_div_sel;
            gate_reg     <= cfg_sysref_gate_en;
        end
    end

    // Analog balance and driver settings; no side effects, so no change detect
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_reg    <= `PHASE_NEUTRAL;
            amp_reg      <= `AMP_NEUTRAL;
            swing_reg    <= `SWING_RESET;
            deemph_reg   <= `DEEMPH_RESET;
        end
        else if (clk_en && cfg_wr)
        begin
            phase_reg    <= cfg_phase_adj;
            amp_reg      <= cfg_amp_adj;
            swing_reg    <= cfg_swing;
            deemph_reg   <= cfg_deemph;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Over-range detector

    logic [`SAMPLE_W-1:0]   magnitude;
    logic [`SAMPLE_W:0]     thr_codes;
    logic                   exceed;
    logic                   exceed_reg;

    assign magnitude = core_sample[`SAMPLE_W-1] ? (~core_sample + 16'h0001) : core_sample;
    assign thr_codes = {8'h00, thr_reg} << `THR_STEP_SHIFT;
    assign exceed    = ({1'b0, magnitude} > thr_codes);

    // Latest comparison, held between sample strobes
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            exceed_reg <= 1'b0;
        else if (clk_en && core_sample_valid)
            exceed_reg <= exceed;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hold counter in frame ticks

    ovr_clk_pkg::hold_state_type state_reg;
    ovr_clk_pkg::hold_state_type state_next;
    logic [`HOLD_CNT_W-1:0]      hold_cnt_reg;
    logic [`HOLD_CNT_W-1:0]      hold_cnt_next;
    logic [`HOLD_CNT_W-1:0]      hold_limit;
    logic                        flag_next;

    assign hold_limit = (hold_sel_reg == 2'h1) ? `HOLD_CYC_1 :
                        (hold_sel_reg == 2'h2) ? `HOLD_CYC_2 :
                        (hold_sel_reg == 2'h3) ? `HOLD_CYC_3 : `HOLD_CYC_0;

    // Flag follows state; the counter only advances on frame ticks
    always_comb
    begin
        state_next    = state_reg;
        hold_cnt_next = hold_cnt_reg;
        case (state_reg)
            ovr_clk_pkg::HOLD_IDLE:
            begin
                hold_cnt_next = `HOLD_CYC_0;
                if (exceed_reg)
                    state_next = ovr_clk_pkg::HOLD_OVER;
            end
            ovr_clk_pkg::HOLD_OVER:
            begin
                hold_cnt_next = `HOLD_CYC_0;
                if (!exceed_reg)
                    state_next = (hold_limit == `HOLD_CYC_0) ? ovr_clk_pkg::HOLD_IDLE
                                                            : ovr_clk_pkg::HOLD_COUNT;
            end
            ovr_clk_pkg::HOLD_COUNT:
            begin
                if (exceed_reg)
                begin
                    state_next    = ovr_clk_pkg::HOLD_OVER;
                    hold_cnt_next = `HOLD_CYC_0;
                end
                else if (frame_tick)
                begin
                    hold_cnt_next = hold_cnt_reg + 4'h1;
                    if (hold_cnt_next >= hold_limit)
                        state_next = ovr_clk_pkg::HOLD_IDLE;
                end
            end
            default:
            begin
                state_next    = ovr_clk_pkg::HOLD_IDLE;
                hold_cnt_next = `HOLD_CYC_0;
            end
        endcase
    end

    assign flag_next = (state_next != ovr_clk_pkg::HOLD_IDLE);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg       <= ovr_clk_pkg::HOLD_IDLE;
            hold_cnt_reg    <= `HOLD_CYC_0;
            over_range_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg       <= state_next;
            hold_cnt_reg    <= hold_cnt_next;
            over_range_flag <= flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared pin, link restart, SYSREF gate, setting outputs

    logic sample_tick_raw;
    logic pin_out_next;
    logic pin_oe_next;
    logic sysref_next;

    assign pin_out_next = indicate_reg ? flag_next : readback_data;
    assign pin_oe_next  = indicate_reg | readback_oe;
    assign sysref_next  = sysref_in & gate_reg;

    clock_divider u_clock_divider
    (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .clk_en      (clk_en),
        .device_tick (device_clock_input),
        .div_sel     (div_reg),
        .restart     (link_restart),
        .sample_tick (sample_tick_raw)
    );

    // Shared pin flops; in indication mode pin and flag load the same next value, so they never skew
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            shared_pin_out       <= 1'b0;
            shared_pin_oe        <= 1'b0;
        end
        else if (clk_en)
        begin
            shared_pin_out       <= pin_out_next;
            shared_pin_oe        <= pin_oe_next;
        end
    end

    // Divider tick, link restart and gated SYSREF; tick re-registered for a flop output
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sample_tick          <= 1'b0;
            link_restart         <= 1'b0;
            sysref_internal      <= 1'b0;
        end
        else if (clk_en)
        begin
            sample_tick          <= sample_tick_raw;
            link_restart         <= div_change;
            sysref_internal      <= sysref_next;
        end
    end

    // Setting outputs; one extra stage costs a cycle but keeps every output on a flop
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_adj            <= `PHASE_NEUTRAL;
            amp_adj              <= `AMP_NEUTRAL;
            output_swing_setting <= `SWING_RESET;
            deemphasis_setting   <= `DEEMPH_RESET;
        end
        else if (clk_en)
        begin
            phase_adj            <= phase_reg;
            amp_adj              <= amp_reg;
            output_swing_setting <= swing_reg;
            deemphasis_setting   <= deemph_reg;
        end
    end

endmodule

// ===== src/clock_divider.sv
// Purpose: divides the device clock input down to the sample rate
// Assumes: device_clock_input is a synchronous enable-style tick stream
// Notes:   emits one sample tick per 1, 2 or 4 device clock ticks
`timescale 1ns/1ps
`include "ovr_clk_consts.svh"

module clock_divider
(
    input  wire logic                     ref_clk,      // Block clock
    input  wire logic                     rst,          // Async reset, high
    input  wire logic                     clk_en,       // Freeze when low
    input  wire logic                     device_tick,  // Device clock tick
    input  wire ovr_clk_pkg::div_sel_type div_sel,      // Divide factor
    input  wire logic                     restart,      // Realign phase
    output logic                          sample_tick   // Sample-rate tick
);

    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic       tick_reg;
    logic       wrap;

    // Terminal count per factor
    assign wrap = (div_sel == ovr_clk_pkg::DIV_BY_1) ? 1'b1 :
                  (div_sel == ovr_clk_pkg::DIV_BY_2) ? (phase_reg[0] == 1'b1) :
                  (phase_reg == 2'h3);
    assign phase_next = (restart | wrap) ? 2'h0 : phase_reg + 2'h1;
    assign sample_tick = tick_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_reg <= 2'h0;
            tick_reg  <= 1'b0;
        end
        else if (clk_en)
        begin
            tick_reg <= device_tick & wrap & ~restart;
            if (device_tick | restart)
                phase_reg <= phase_next;
        end
    end

endmodule

// ===== src/ovr_clk_consts.svh
// Purpose: constants for the over-range and clock control block
// Assumes: 250 MHz ref_clk
// Notes:   widths, setting resets and hold counts live here; pin mode and SYSREF gate reset to 0 in the block
`ifndef OVR_CLK_CONSTS_SVH
`define OVR_CLK_CONSTS_SVH

`define SAMPLE_W          16
`define THR_STEP_SHIFT    7
`define THR_W             9
`define THR_RESET         9'h1FF
`define HOLD_SEL_W        2
`define HOLD_SEL_RESET    2'h0
`define HOLD_CNT_W        4
`define HOLD_CYC_0        4'h0
`define HOLD_CYC_1        4'h3
`define HOLD_CYC_2        4'h7
`define HOLD_CYC_3        4'hF
`define DIV_SEL_RESET     2'h0
`define PHASE_W           4
`define AMP_W             3
`define PHASE_NEUTRAL     4'h0
`define AMP_NEUTRAL       3'h0
`define DRV_W             3
`define SWING_RESET       3'h0
`define DEEMPH_RESET      3'h0
`define LINK_RESTART_CYC  2'h2

`endif

// ===== src/ovr_clk_pkg.sv
// Purpose: shared types for the over-range and clock control block
// Assumes: nothing
// Notes:   constants are in ovr_clk_consts.svh
package ovr_clk_pkg;

    typedef enum logic [1:0]
    {
        DIV_BY_1 = 2'b00,
        DIV_BY_2 = 2'b01,
        DIV_BY_4 = 2'b10
    } div_sel_type;

    typedef enum logic [1:0]
    {
        HOLD_IDLE    = 2'b00,
        HOLD_OVER    = 2'b01,
        HOLD_COUNT   = 2'b10
    } hold_state_type;

endpackage
